// ==== verilog/aer_consts.svh ====
// constants of the error reporting register bank: offsets, field masks, resets
// assumes a 12-bit configuration byte address and 32-bit data words
// Notes on behaviour
// [R1] sticky writable severity bits, one means fatal
// [R2] receiver error sets status bit 0, write-one-clear
// [R3] bad packet integrity sets status bit 6
// [R4] corrupted link layer packet sets bit 7
// [R5] replay counter rollover sets status bit 8
// [R6] replay timer expiry sets status bit 12
// [R7] mask bit 0 stops receiver error log/message
// [R8] mask bit 6 stops bad packet log/message
// [R9] mask bit 7 stops bad link packet reporting
// [R10] mask bit 8 stops rollover log/message
// [R11] mask bit 12 stops timer expiry reporting
// [R12] five-bit sticky pointer to first uncorrectable error
// [R13] capability bits 5 and 7 read one
// [R14] bit 6 enables end-to-end crc generation
// [R15] bit 8 enables end-to-end crc checking
// [R16] logging captures four header words, big-endian
// [R17] reserved bits read as zero
// [R18] training error sets uncorrectable status bit 0
// [R19] sticky state survives ordinary reset, cleared at power-on; the severity register loads 0x0006_2011 at power-on instead
`ifndef AER_CONSTS_SVH
`define AER_CONSTS_SVH

`define AER_OFF_UNC_STATUS   12'h104
`define AER_OFF_UNC_SEV      12'h10c
`define AER_OFF_COR_STATUS   12'h110
`define AER_OFF_COR_MASK     12'h114
`define AER_OFF_CAP_CTRL     12'h118
`define AER_OFF_HDR_LOG0     12'h11c
`define AER_OFF_HDR_LOG1     12'h120
`define AER_OFF_HDR_LOG2     12'h124
`define AER_OFF_HDR_LOG3     12'h128
`define AER_OFF_INT_STATUS   12'h130
`define AER_OFF_INT_ENABLE   12'h134
`define AER_OFF_INT_CLEAR    12'h138

`define AER_UNC_MASK         32'h0000_0011
`define AER_SEV_MASK         32'h001f_f011
`define AER_SEV_RESET        32'h0006_2011
`define AER_COR_MASK         32'h0000_11c1
`define AER_CTRL_WMASK       32'h0000_0140
`define AER_CTRL_CAPS        32'h0000_00a0
`define AER_BIT_RX_ERR       0
`define AER_BIT_BAD_TLP      6
`define AER_BIT_BAD_DLLP     7
`define AER_BIT_REPLAY_ROLL  8
`define AER_BIT_REPLAY_TMO   12
`define AER_BIT_TRAIN_ERR    0
`define AER_BIT_DLP_ERR      4
`define AER_BIT_ECRC_GEN     6
`define AER_BIT_ECRC_CHK     8
`define AER_INT_BITS         3

`endif

// ==== verilog/aer_pkg.sv ====
// types shared by the error reporting register bank and its header log
// assumes the link-layer detectors run on the register clock
package aer_pkg;

    typedef struct packed {
        logic         rx_err;
        logic         bad_tlp;
        logic         bad_dllp;
        logic         replay_roll;
        logic         replay_tmo;
        logic         train_err;
        logic         dlp_err;
        logic [127:0] hdr;
    } aer_evt_t;

    typedef struct packed {
        logic       valid;
        logic       corr;
        logic       fatal;
        logic [4:0] bit_pos;
    } aer_msg_t;

    typedef enum logic [1:0] {
        AER_IDLE = 2'b00,
        AER_DONE = 2'b01
    } aer_bus_st_t;

endpackage

// ==== verilog/aer_hdr_log.sv ====
// header log: four words captured from an offending packet header
// assumes header byte n arrives at hdr_in[8n+7:8n], byte 0 first on the link
`timescale 1ns/100ps
`include "aer_consts.svh"

module aer_hdr_log (
    input  wire logic         pclk,
    input  wire logic         por_n,
    input  wire logic         ce,
    input  wire logic         cap,
    input  wire logic [127:0] hdr_in,
    input  wire logic [1:0]   rd_idx,
    output logic      [31:0]  rd_word
);
    import aer_pkg::*;

    logic [127:0] log_r;
    logic [127:0] log_swapped;
    logic [127:0] log_nxt;

    // first byte of each word lands in its top byte lane
    genvar b;
    generate
        for (b = 0; b < 16; b = b + 1)
        begin : g_byte
            assign log_swapped[32*(b/4) + 8*(3-(b%4)) +: 8] = hdr_in[8*b +: 8]; // R16
        end
    endgenerate

    always_comb
    begin
        log_nxt = log_r;
        if (ce && cap)
            log_nxt = log_swapped; // R16
    end

    // sticky, kept across ordinary reset
    always_ff @(posedge pclk or negedge por_n)
    begin
        if (!por_n)
            log_r <= 128'h0; // R19
        else
            log_r <= log_nxt;
    end

    assign rd_word = log_r[32*rd_idx +: 32];

    property p_hdr_be;
        @(posedge pclk) disable iff (!por_n)
        (ce && cap) |=> (log_r[31:24] == $past(hdr_in[7:0]))
                        && (log_r[127:120] == $past(hdr_in[103:96]));
    endproperty
    a_hdr_be: assert property (p_hdr_be) else $error("header log byte order wrong"); // R16

endmodule // aer_hdr_log

// ==== verilog/aer_regs.sv ====
// error reporting register bank with apb slave, error messages and interrupt
// assumes event pulses come from link logic on pclk; por_n is power-on reset
`timescale 1ns/100ps
`include "aer_consts.svh"

module aer_regs (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             por_n,
    input  wire logic             ce,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire aer_pkg::aer_evt_t evt,
    output aer_pkg::aer_msg_t     err_msg,
    output logic                  ecrc_gen_en,
    output logic                  ecrc_chk_en,
    output logic                  irq
);
    import aer_pkg::*;

    // sticky state
    logic [31:0] unc_r;
    logic [31:0] unc_nxt;
    logic [31:0] sev_r;
    logic [31:0] sev_nxt;
    logic [31:0] cst_r;
    logic [31:0] cst_nxt;
    logic [31:0] cmask_r;
    logic [31:0] cmask_nxt;
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [4:0]  fep_r;
    logic [4:0]  fep_nxt;

    // ordinary state
    aer_bus_st_t             bus_r;
    aer_bus_st_t             bus_nxt;
    logic [31:0]             prdata_r;
    logic [31:0]             prdata_nxt;
    logic                    pslverr_r;
    logic                    pslverr_nxt;
    logic [`AER_INT_BITS-1:0] ist_r;
    logic [`AER_INT_BITS-1:0] ist_nxt;
    logic [`AER_INT_BITS-1:0] ien_r;
    logic [`AER_INT_BITS-1:0] ien_nxt;
    logic                    irq_r;
    logic                    irq_nxt;
    aer_msg_t                msg_r;
    aer_msg_t                msg_nxt;

    logic [31:0] cor_evt;
    logic [31:0] unc_evt;
    logic [31:0] cor_log;
    logic        log_any;
    logic        unc_fatal;
    logic        wr_done;
    logic        rd_take;
    logic [31:0] hdr_word;

    function automatic logic [4:0] aer_lowest(input logic [31:0] v);
        logic [4:0] pos;
        pos = 5'h00;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
                pos = 5'(i);
        end
        return pos;
    endfunction

    // event vectors in register bit positions
    always_comb
    begin
        cor_evt = 32'h0;
        cor_evt[`AER_BIT_RX_ERR]      = evt.rx_err;      // R2
        cor_evt[`AER_BIT_BAD_TLP]     = evt.bad_tlp;     // R3
        cor_evt[`AER_BIT_BAD_DLLP]    = evt.bad_dllp;    // R4
        cor_evt[`AER_BIT_REPLAY_ROLL] = evt.replay_roll; // R5
        cor_evt[`AER_BIT_REPLAY_TMO]  = evt.replay_tmo;  // R6
        unc_evt = 32'h0;
        unc_evt[`AER_BIT_TRAIN_ERR]   = evt.train_err;   // R18
        unc_evt[`AER_BIT_DLP_ERR]     = evt.dlp_err;
        // masked correctable events are neither logged nor reported
        cor_log   = cor_evt & ~cmask_r;                  // R7 R8 R9 R10 R11
        log_any   = (|cor_log) || (|unc_evt);
        unc_fatal = |(unc_evt & sev_r);                  // R1
    end

    // a write takes effect only at the edge where pready is seen high; read data is taken one edge earlier, while pready is low
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_take = psel && penable && (bus_r == AER_IDLE) && !pwrite;

    always_comb
    begin
        unc_nxt   = unc_r;
        sev_nxt   = sev_r;
        cst_nxt   = cst_r;
        cmask_nxt = cmask_r;
        ctrl_nxt  = ctrl_r;
        fep_nxt   = fep_r;
        if (ce)
        begin
            if (wr_done)
            begin
                case (paddr)
                    `AER_OFF_UNC_STATUS: unc_nxt = unc_r & ~(pwdata & `AER_UNC_MASK);
                    `AER_OFF_UNC_SEV:    sev_nxt = pwdata & `AER_SEV_MASK; // R1
                    `AER_OFF_COR_STATUS: cst_nxt = cst_r & ~(pwdata & `AER_COR_MASK); // R2
                    `AER_OFF_COR_MASK:   cmask_nxt = pwdata & `AER_COR_MASK;
                    `AER_OFF_CAP_CTRL:   ctrl_nxt = pwdata & `AER_CTRL_WMASK; // R14 R15
                    default:             ;
                endcase
            end
            // set wins over a clear in the same cycle
            cst_nxt = cst_nxt | cor_evt;  // R2 R3 R4 R5 R6
            unc_nxt = unc_nxt | unc_evt;  // R18
            // pointer only moves when no uncorrectable error was pending
            if ((|unc_evt) && !(|unc_r))
                fep_nxt = aer_lowest(unc_evt); // R12
        end
    end

    always_ff @(posedge pclk or negedge por_n)
    begin
        if (!por_n)
        begin
            unc_r   <= 32'h0;                // R19
            sev_r   <= `AER_SEV_RESET;
            cst_r   <= 32'h0;
            cmask_r <= 32'h0;
            ctrl_r  <= 32'h0;                // R14 R15
            fep_r   <= 5'h00;
        end
        else
        begin
            unc_r   <= unc_nxt;
            sev_r   <= sev_nxt;
            cst_r   <= cst_nxt;
            cmask_r <= cmask_nxt;
            ctrl_r  <= ctrl_nxt;
            fep_r   <= fep_nxt;
        end
    end

    aer_hdr_log u_hdr_log (
        .pclk    (pclk),
        .por_n   (por_n),
        .ce      (ce),
        .cap     (log_any),
        .hdr_in  (evt.hdr),
        .rd_idx  (2'(paddr[3:2] - 2'h3)),
        .rd_word (hdr_word)
    );

    // one wait state: read data is registered so prdata leaves a flop
    always_comb
    begin
        bus_nxt     = bus_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        ist_nxt     = ist_r;
        ien_nxt     = ien_r;
        irq_nxt     = irq_r;
        msg_nxt     = msg_r;
        if (ce)
        begin
            case (bus_r)
                AER_IDLE:
                begin
                    if (psel && penable)
                        bus_nxt = AER_DONE;
                end
                AER_DONE:
                    bus_nxt = AER_IDLE;
                default:
                    bus_nxt = AER_IDLE;
            endcase
            if (psel && penable && (bus_r == AER_IDLE))
            begin
                prdata_nxt  = 32'h0;   // R17
                pslverr_nxt = 1'b0;
                case (paddr)
                    `AER_OFF_UNC_STATUS: prdata_nxt = unc_r;
                    `AER_OFF_UNC_SEV:    prdata_nxt = sev_r;
                    `AER_OFF_COR_STATUS: prdata_nxt = cst_r;
                    `AER_OFF_COR_MASK:   prdata_nxt = cmask_r;
                    `AER_OFF_CAP_CTRL:   prdata_nxt = ctrl_r | `AER_CTRL_CAPS | 32'(fep_r); // R13 R12
                    `AER_OFF_HDR_LOG0, `AER_OFF_HDR_LOG1, `AER_OFF_HDR_LOG2, `AER_OFF_HDR_LOG3:
                                         prdata_nxt = hdr_word; // R16
                    `AER_OFF_INT_STATUS: prdata_nxt = 32'(ist_r);
                    `AER_OFF_INT_ENABLE: prdata_nxt = 32'(ien_r);
                    `AER_OFF_INT_CLEAR:  prdata_nxt = 32'h0;
                    default:             pslverr_nxt = 1'b1;
                endcase
                if (!rd_take)
                    prdata_nxt = 32'h0;
            end
            else if (bus_r == AER_DONE)
            begin
                prdata_nxt  = 32'h0;
                pslverr_nxt = 1'b0;
            end
            if (wr_done && (paddr == `AER_OFF_INT_ENABLE))
                ien_nxt = pwdata[`AER_INT_BITS-1:0];
            if (wr_done && (paddr == `AER_OFF_INT_CLEAR))
                ist_nxt = ist_r & ~pwdata[`AER_INT_BITS-1:0];
            // events after the clear so a same-cycle event is kept
            ist_nxt[0] = ist_nxt[0] | (|cor_log);
            ist_nxt[1] = ist_nxt[1] | ((|unc_evt) && !unc_fatal);
            ist_nxt[2] = ist_nxt[2] | unc_fatal;
            irq_nxt = |(ist_nxt & ien_nxt);
            msg_nxt.valid   = log_any;                 // R7 R8 R9 R10 R11
            msg_nxt.corr    = (|cor_log) && !(|unc_evt);
            msg_nxt.fatal   = unc_fatal;               // R1
            msg_nxt.bit_pos = (|unc_evt) ? aer_lowest(unc_evt) : aer_lowest(cor_log);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_r     <= AER_IDLE;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
            ist_r     <= '0;
            ien_r     <= '0;
            irq_r     <= 1'b0;
            msg_r     <= '0;
        end
        else
        begin
            bus_r     <= bus_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            ist_r     <= ist_nxt;
            ien_r     <= ien_nxt;
            irq_r     <= irq_nxt;
            msg_r     <= msg_nxt;
        end
    end

    assign prdata      = prdata_r;
    // done is the only state code with bit 0 set, so pready is a bare flop bit
    assign pready      = bus_r[0];
    assign pslverr     = pslverr_r;
    assign err_msg     = msg_r;
    assign ecrc_gen_en = ctrl_r[`AER_BIT_ECRC_GEN]; // R14
    assign ecrc_chk_en = ctrl_r[`AER_BIT_ECRC_CHK]; // R15
    assign irq         = irq_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !por_n);

    property p_sev_write;
        (ce && wr_done && paddr == `AER_OFF_UNC_SEV)
            |=> (sev_r == ($past(pwdata) & `AER_SEV_MASK));
    endproperty
    a_sev_write: assert property (p_sev_write) else $error("severity write lost"); // R1

    property p_rx_set;
        (ce && evt.rx_err) |=> cst_r[0] && (cst_r[31:13] == 19'h0);
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("receiver error not logged"); // R2

    property p_bad_tlp;
        (ce && evt.bad_tlp) |=> cst_r[6];
    endproperty
    a_bad_tlp: assert property (p_bad_tlp) else $error("bad packet status not set"); // R3

    property p_bad_dllp;
        (ce && evt.bad_dllp) |=> cst_r[7];
    endproperty
    a_bad_dllp: assert property (p_bad_dllp) else $error("bad link packet not set"); // R4

    sequence s_roll;
        ce && evt.replay_roll;
    endsequence
    property p_roll;
        s_roll |=> cst_r[8];
    endproperty
    a_roll: assert property (p_roll) else $error("rollover status not set"); // R5

    property p_tmo;
        (ce && evt.replay_tmo) |=> cst_r[12];
    endproperty
    a_tmo: assert property (p_tmo) else $error("replay timeout not set"); // R6

    property p_mask_rx;
        (ce && evt.rx_err && cmask_r[0] && !(|cor_log) && !(|unc_evt))
            |=> !err_msg.valid;
    endproperty
    a_mask_rx: assert property (p_mask_rx) else $error("masked receiver error reported"); // R7

    property p_unmasked_msg;
        (ce && (|(cor_evt & ~cmask_r))) |=> err_msg.valid && !err_msg.fatal;
    endproperty
    a_unmasked_msg: assert property (p_unmasked_msg) else $error("unmasked event not sent"); // R8

    property p_fep;
        (ce && evt.train_err && !(|unc_r)) |=> unc_r[0] && (fep_r == 5'h00);
    endproperty
    a_fep: assert property (p_fep) else $error("first error pointer wrong"); // R12

    sequence s_cap_read;
        psel && penable && !pwrite && (paddr == `AER_OFF_CAP_CTRL) && pready;
    endsequence
    property p_caps;
        s_cap_read |-> prdata[5] && prdata[7] && (prdata[31:9] == 23'h0);
    endproperty
    a_caps: assert property (p_caps) else $error("capability bits wrong"); // R13

    property p_ecrc_gen;
        (ce && wr_done && paddr == `AER_OFF_CAP_CTRL)
            |=> (ecrc_gen_en == $past(pwdata[6])) && (ecrc_chk_en == $past(pwdata[8]));
    endproperty
    a_ecrc_gen: assert property (p_ecrc_gen) else $error("crc enables not updated"); // R14

    property p_ecrc_chk;
        (ce && wr_done && paddr == `AER_OFF_CAP_CTRL) |=> (ecrc_chk_en == $past(pwdata[8]));
    endproperty
    a_ecrc_chk: assert property (p_ecrc_chk) else $error("crc check enable not updated"); // R15

    property p_mask_dllp;
        (ce && evt.bad_dllp && cmask_r[7] && !(|cor_log) && !(|unc_evt)) |=> !err_msg.valid;
    endproperty
    a_mask_dllp: assert property (p_mask_dllp) else $error("masked bad link packet sent"); // R9

    property p_mask_roll;
        (ce && evt.replay_roll && cmask_r[8] && !(|cor_log) && !(|unc_evt)) |=> !err_msg.valid;
    endproperty
    a_mask_roll: assert property (p_mask_roll) else $error("masked rollover sent"); // R10

    property p_mask_tmo;
        (ce && evt.replay_tmo && cmask_r[12] && !(|cor_log) && !(|unc_evt)) |=> !err_msg.valid;
    endproperty
    a_mask_tmo: assert property (p_mask_tmo) else $error("masked replay timeout sent"); // R11

    // reserved status and mask bits 31:13 must never hold a one
    property p_resv;
        (cst_r[31:13] == 19'h0) && (cmask_r[31:13] == 19'h0);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set"); // R17

endmodule // aer_regs

// ==== test/aer_rc_model.sv ====
// upstream error message sink: counts messages and keeps the last one
// assumes one-cycle valid pulses on pclk; rst_n is tied to power-on reset
`timescale 1ns/100ps

module aer_rc_model (
    input  wire logic              pclk,
    input  wire logic              rst_n,
    input  wire aer_pkg::aer_msg_t msg,
    output logic [7:0]             msg_count,
    output aer_pkg::aer_msg_t      last_msg
);
    import aer_pkg::*;

    // takes a message whole in its one valid cycle; never stalls the sender
    always_ff @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_count <= 8'h00;
            last_msg  <= '0;
        end
        else if (msg.valid)
        begin
            msg_count <= msg_count + 8'h01;
            last_msg  <= msg;
        end
    end
endmodule // aer_rc_model

// ==== test/tb_top.sv ====
// self-checking bench for the error reporting register bank
// assumes aer_regs and the message sink model are compiled first
`timescale 1ns/100ps

module tb_top;
    import aer_pkg::*;
    logic         pclk;
    logic         presetn;
    logic         por_n;
    logic         ce;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    aer_evt_t     evt;
    aer_msg_t     err_msg;
    aer_msg_t     last_msg;
    logic         ecrc_gen_en;
    logic         ecrc_chk_en;
    logic         irq;
    logic [7:0]   msg_count;
    logic [7:0]   cnt0;
    logic [31:0]  rd;
    logic         slverr_seen;
    logic [127:0] h;
    int           fails;
    int           samples_checked;
    int           cbit [5] = '{0, 6, 7, 8, 12};

    aer_regs i_aer_regs (.pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .err_msg(err_msg),
        .ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en), .irq(irq));

    aer_rc_model i_aer_rc_model (.pclk(pclk), .rst_n(por_n), .msg(err_msg),
        .msg_count(msg_count), .last_msg(last_msg));

    task automatic conclude;
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // request held until the edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slverr_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // f: rx_err, bad_tlp, bad_dllp, replay_roll, replay_tmo, train_err, dlp_err
    task automatic ev(input logic [6:0] f, input logic [127:0] hv);
        @(posedge pclk);
        evt <= {f, hv};
        @(posedge pclk);
        evt <= '0;
        repeat (2) @(posedge pclk);
    endtask

    // header byte 4k lands in the top byte of word k
    function automatic logic [31:0] hw(input logic [127:0] hv, input int k);
        return {hv[32*k+:8], hv[32*k+8+:8], hv[32*k+16+:8], hv[32*k+24+:8]};
    endfunction

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // whole run is well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        conclude();
    end

    initial
    begin
        presetn = 1'b0;
        por_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        evt     = '0;
        ce      = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        rdc(12'h10c, 32'h0006_2011);
        rdc(12'h110, 32'h0);
        rdc(12'h114, 32'h0);
        rdc(12'h118, 32'h0000_00a0);
        chk({30'h0, ecrc_chk_en, ecrc_gen_en}, 32'h0);
        apb(1'b1, 12'h10c, 32'hffff_ffff);
        rdc(12'h10c, 32'h001f_f011);
        apb(1'b1, 12'h10c, 32'h0000_0010);
        rdc(12'h10c, 32'h0000_0010);
        apb(1'b1, 12'h134, 32'h7);
        for (int i = 0; i < 5; i++)
        begin
            h = {16{8'(8'h11 * i)}} ^ 128'h0f0e0d0c_0b0a0908_07060504_03020100;
            cnt0 = msg_count;
            ev(7'h40 >> i, h);
            chk(32'(msg_count - cnt0), 32'h1);
            chk(32'(last_msg), 32'hc0 | cbit[i]);
            chk({31'h0, irq}, 32'h1);
            rdc(12'h110, 32'h1 << cbit[i]);
            for (int k = 0; k < 4; k++)
                rdc(12'h11c + 12'(4 * k), hw(h, k));
            apb(1'b1, 12'h138, 32'h1);
            repeat (2) @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, 12'h110, 32'h1 << cbit[i]);
            rdc(12'h110, 32'h0);
        end
        // masked events still set status but leave log and messages alone
        apb(1'b1, 12'h114, 32'hffff_ffff);
        rdc(12'h114, 32'h0000_11c1);
        cnt0 = msg_count;
        ev(7'h7c, ~h);
        chk(32'(msg_count - cnt0), 32'h0);
        rdc(12'h11c, hw(h, 0));
        rdc(12'h110, 32'h0000_11c1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h110, 32'h0000_0100);
        rdc(12'h110, 32'h0000_10c1);
        apb(1'b1, 12'h114, 32'h0);
        apb(1'b1, 12'h118, 32'hffff_ffff);
        rdc(12'h118, 32'h0000_01e0);
        chk({30'h0, ecrc_chk_en, ecrc_gen_en}, 32'h3);
        cnt0 = msg_count;
        ev(7'h02, h);
        chk(32'(last_msg), 32'h80);
        chk({31'h0, irq}, 32'h1);
        rdc(12'h104, 32'h01);
        rdc(12'h118, 32'h0000_01e0);
        apb(1'b1, 12'h104, 32'h1);
        ev(7'h01, h);
        chk(32'(last_msg), 32'ha4);
        chk(32'(msg_count - cnt0), 32'h2);
        rdc(12'h104, 32'h10);
        rdc(12'h118, 32'h0000_01e4);
        apb(1'b0, 12'h200, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, slverr_seen}, 32'h1);
        // frozen clock enable: an event pulse leaves no trace
        cnt0 = msg_count;
        ce <= 1'b0;
        ev(7'h08, h);
        ce <= 1'b1;
        chk(32'(msg_count - cnt0), 32'h0);
        rdc(12'h110, 32'h0000_10c1);
        // ordinary reset keeps sticky state, power-on reset clears it except severity, which returns to 0x0006_2011
        apb(1'b1, 12'h114, 32'h0000_0041);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, irq}, 32'h0);
        rdc(12'h114, 32'h0000_0041);
        rdc(12'h110, 32'h0000_10c1);
        rdc(12'h118, 32'h0000_01e4);
        rdc(12'h10c, 32'h0000_0010);
        rdc(12'h128, hw(h, 3));
        por_n   <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        por_n   <= 1'b1;
        presetn <= 1'b1;
        rdc(12'h118, 32'h0000_00a0);
        rdc(12'h110, 32'h0);
        rdc(12'h11c, 32'h0);
        conclude();
    end
endmodule // tb_top
